/* core/ifl_ctrl.sv */
// ifl_ctrl: ignition sequence supervisor with fault handling and led codes
// assumes raw pins on i_pins (synchronised here) and flame current from
// an on-chip converter on the same clock, in quarter microamps
`timescale 1ns/10ps
module ifl_ctrl
  import ifl_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire ifl_pins_s i_pins,
  input wire logic [7:0] i_flame_cur,
  output logic o_pilot,
  output logic o_spark,
  output logic o_main,
  output logic o_damp,
  output ifl_st_e o_state,
  output ifl_req_s o_shown,
  output ifl_lv_e o_led_lvl
);

  ifl_top_s s;
  ifl_top_s next;
  logic led_done;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // wait-state code by fixed priority; only one is ever on the led
  function automatic logic [7:0] fault_code(input ifl_pins_s p);
    if (p.int_err)
      return CODE_INTERNAL;
    else if (p.rod_short)
      return CODE_ROD;
    else
      return CODE_LOWV;
  endfunction : fault_code

  // heat call ended: close a fitted damper first, else straight to idle
  function automatic ifl_st_e leave_st(input ifl_pins_s p);
    return p.damp_req ? ST_DCLOSE : ST_IDLE;
  endfunction : leave_st

  // ****************************************************************
  // sequence state machine
  // ****************************************************************
  always_comb
  begin
    ifl_pins_s p;
    logic fault;
    logic [8:0] cur_sum;
    p = s.sync2;
    fault = p.int_err | p.rod_short | p.low_volt;
    cur_sum = {1'b0, i_flame_cur} + CUR_HALF;
    next = s;
    // two-flop synchroniser for every pin
    next.sync1 = i_pins;
    next.sync2 = s.sync1;
    // 1 ms tick; long timers count ticks so a fast tick shortens all of them
    next.tick = (s.pre == PW'(TICK_CYC_P - 1));
    next.pre = next.tick ? '0 : s.pre + 1'b1;
    if (s.tick && s.tmr != '1)
      next.tmr = s.tmr + 1'b1;
    // faults win over any sequence step once self check is done
    if (s.st != ST_SELF && fault)
    begin
      if (s.st != ST_WAIT)
      begin
        next.st = ST_WAIT;
        next.tmr = '0;
      end
    end
    else
    begin
      case (s.st)
        ST_SELF:
          if (s.tick && s.tmr == SELF_T)
          begin
            next.st = ST_IDLE;
            next.tmr = '0;
          end
        ST_WAIT:
        begin
          next.st = ST_IDLE;
          next.tmr = '0;
        end
        ST_IDLE:
        begin
          next.tmr = '0;
          next.rec = 1'b0;
          if (p.flame)
          begin
            next.st = ST_OOS;
            next.long_oos = 1'b0;
          end
          else if (p.heat && p.damp_req && !p.damp_present)
            next.st = ST_DERR;
          else if (p.heat && p.damp_req)
            next.st = ST_DOPEN;
          else if (p.heat)
            next.st = ST_TRIAL;
        end
        ST_DOPEN:
        begin
          if (!p.heat)
            next.st = ST_DCLOSE;
          else if (p.flame)
          begin
            next.st = ST_OOS;
            next.long_oos = 1'b0;
          end
          else if (p.damp_open)
            next.st = ST_TRIAL;
          else if (s.tick && s.tmr == DAMP_T)
            next.st = ST_DERR;
          if (next.st != s.st)
            next.tmr = '0;
        end
        ST_TRIAL:
        begin
          if (!p.heat)
            next.st = leave_st(p);
          else if (p.flame)
          begin
            next.st = ST_RUN;
            next.rec = 1'b0;
          end
          else if (s.tick && s.tmr == TRIAL_T)
            next.st = ST_RETRY;
          if (next.st != s.st)
            next.tmr = '0;
        end
        ST_RUN:
        begin
          if (!p.heat)
            next.st = leave_st(p);
          else if (!p.flame)
          begin
            next.st = ST_TRIAL;
            next.rec = 1'b1;
          end
          if (next.st != s.st)
            next.tmr = '0;
        end
        ST_RETRY:
        begin
          if (!p.heat)
            next.st = leave_st(p);
          else if (p.flame)
          begin
            next.st = ST_OOS;
            next.long_oos = 1'b0;
          end
          else if (s.tick && s.tmr == RETRY_T)
            next.st = ST_TRIAL;
          if (next.st != s.st)
            next.tmr = '0;
        end
        ST_OOS:
        begin
          if (!p.flame)
          begin
            next.st = s.long_oos ? ST_HOLD : ST_IDLE;
            next.tmr = '0;
          end
          else if (s.tick && s.tmr == OOS_T)
            next.long_oos = 1'b1;
        end
        ST_HOLD:
        begin
          // a flame returning during the hold restarts the whole check
          if (p.flame)
          begin
            next.st = ST_OOS;
            next.long_oos = 1'b0;
            next.tmr = '0;
          end
          else if (s.tick && s.tmr == HOLD_T)
          begin
            next.st = ST_IDLE;
            next.tmr = '0;
          end
        end
        ST_DERR:
          if ((!p.damp_req || p.damp_present) && (p.damp_open == s.act.damp))
          begin
            next.st = ST_IDLE;
            next.tmr = '0;
          end
        ST_DCLOSE:
          if (!p.damp_open)
          begin
            next.st = ST_IDLE;
            next.tmr = '0;
          end
          else if (s.tick && s.tmr == DAMP_T)
          begin
            next.st = ST_DERR;
            next.tmr = '0;
          end
        default:
        begin
          next.st = ST_IDLE;
          next.tmr = '0;
        end
      endcase
    end
    // actuators follow the next state so every output is a flop
    next.act.spark = (next.st == ST_TRIAL);
    next.act.pilot = (next.st == ST_TRIAL) || (next.st == ST_RUN);
    next.act.main = (next.st == ST_RUN);
    next.act.damp = p.heat && p.damp_req &&
                    ((next.st == ST_DOPEN) || (next.st == ST_TRIAL) ||
                     (next.st == ST_RUN) || (next.st == ST_RETRY) || (next.st == ST_DERR));
    // led request for the next state
    next.req.n = 8'h00;
    case (next.st)
      ST_SELF: next.req.mode = LM_FAST;
      ST_IDLE, ST_DCLOSE: next.req.mode = LM_OFF;
      ST_DOPEN: next.req.mode = LM_HEART;
      ST_TRIAL:
        if (next.rec)
        begin
          next.req.mode = LM_CODE;
          next.req.n = CODE_RECYCLE;
        end
        else
          next.req.mode = LM_HEART;
      ST_RUN:
      begin
        next.req.mode = LM_CUR;
        next.req.n = {1'b0, cur_sum[CUR_FRAC +: 7]} & 8'h3f;
      end
      ST_RETRY:
      begin
        next.req.mode = LM_CODE;
        next.req.n = CODE_NOFLAME;
      end
      ST_OOS, ST_HOLD:
      begin
        next.req.mode = LM_CODE;
        next.req.n = CODE_OOS;
      end
      ST_DERR:
      begin
        next.req.mode = LM_CODE;
        next.req.n = CODE_DAMP;
      end
      default:
      begin
        next.req.mode = LM_CODE;
        next.req.n = fault_code(p);
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      s <= TOP_RST;
    else
      s <= next;
  end

  // ****************************************************************
  // led player and outputs
  // ****************************************************************
  ifl_led u_led (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_tick(s.tick),
    .i_req(s.req),
    .o_lvl(o_led_lvl),
    .o_done(led_done)
  );

  assign o_pilot = s.act.pilot;
  assign o_spark = s.act.spark;
  assign o_main = s.act.main;
  assign o_damp = s.act.damp;
  assign o_state = s.st;
  assign o_shown = s.req;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  logic flt;
  assign flt = s.sync2.int_err | s.sync2.rod_short | s.sync2.low_volt;

  sequence s_flame_lost;
    s.st == ST_RUN && s.sync2.heat && !s.sync2.flame && !flt;
  endsequence
  sequence s_recycle;
    s.st == ST_TRIAL && s.rec && s.req.n == CODE_RECYCLE && s.act.spark;
  endsequence
  property p_recycle;
    s_flame_lost |=> s_recycle;
  endproperty
  a_recycle: assert property (p_recycle) else $error("no recycle on flame loss");

  property p_oos;
    (s.st == ST_IDLE && s.sync2.flame && !flt) |=> (s.st == ST_OOS && s.req.n == CODE_OOS);
  endproperty
  a_oos: assert property (p_oos) else $error("out of sequence flame missed");

  property p_oos_short;
    (s.st == ST_OOS && !s.long_oos && !s.sync2.flame && !flt) |=> (s.st == ST_IDLE);
  endproperty
  a_oos_short: assert property (p_oos_short) else $error("short oos not resumed");

  property p_oos_long;
    (s.st == ST_OOS && s.long_oos && !s.sync2.flame && !flt) |=> (s.st == ST_HOLD && s.tmr == '0);
  endproperty
  a_oos_long: assert property (p_oos_long) else $error("long oos not held");

  property p_damp_open;
    (s.st == ST_DOPEN && s.tick && s.tmr == DAMP_T && s.sync2.heat && !s.sync2.flame &&
     !s.sync2.damp_open && !flt) |=> (s.st == ST_DERR && s.req.n == CODE_DAMP);
  endproperty
  a_damp_open: assert property (p_damp_open) else $error("damper open timeout missed");

  property p_wait;
    (s.st != ST_SELF && flt) |=> (s.st == ST_WAIT && !s.act.pilot && !s.act.main);
  endproperty
  a_wait: assert property (p_wait) else $error("fault did not force wait");

  property p_cur_run;
    (s.req.mode == LM_CUR) |-> (s.st == ST_RUN && s.act.main);
  endproperty
  a_cur_run: assert property (p_cur_run) else $error("current readout outside run");

  property p_retry;
    (s.st == ST_RETRY && s.tick && s.tmr == RETRY_T && s.sync2.heat && !s.sync2.flame && !flt)
      |=> (s.st == ST_TRIAL && s.act.spark);
  endproperty
  a_retry: assert property (p_retry) else $error("retry did not start trial");

  property p_idle_dark;
    (s.st == ST_IDLE) |-> (s.req.mode == LM_OFF);
  endproperty
  a_idle_dark: assert property (p_idle_dark) else $error("led lit without heat call");

  property p_led_start;
    (led_done && $past(s.req.mode) != LM_OFF) |-> (o_led_lvl == LV_ON);
  endproperty
  a_led_start: assert property (p_led_start) else $error("new pattern did not start lit");

endmodule : ifl_ctrl

/* core/ifl_led.sv */
// ifl_led: status led pattern player (off, fast, heartbeat, code, current)
// assumes a 1 ms tick pulse from the same clock; request may change any time
`timescale 1ns/10ps
module ifl_led
  import ifl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_tick,
  input wire ifl_req_s i_req,
  output ifl_lv_e o_lvl,
  output logic o_done
);

  ifl_led_s s;
  ifl_led_s next;

  // ****************************************************************
  // pattern sequencer
  // ****************************************************************
  always_comb
  begin
    logic [LW-1:0] len;
    logic last;
    len = GAP_L;
    last = 1'b0;
    next = s;
    next.done = 1'b0;
    // phase length for the pattern being played
    case (s.ph)
      PH_LEAD: len = LEAD_L;
      PH_ON, PH_OFF:
        if (s.req.mode == LM_FAST)
          len = FAST_L;
        else if (s.req.mode == LM_HEART)
          len = HEART_L;
        else if (s.req.mode == LM_CUR)
          len = CFL_L;
        else
          len = CODE_L;
      default: len = (s.req.mode == LM_OFF) ? OFFP_L : GAP_L;
    endcase
    if (i_tick)
    begin
      if (s.tmr != len)
        next.tmr = s.tmr + 1'b1;
      else
      begin
        next.tmr = '0;
        case (s.ph)
          PH_LEAD: next.ph = (s.req.n == 8'h00) ? PH_GAP : PH_ON;
          PH_ON: next.ph = PH_OFF;
          PH_OFF:
          begin
            next.cnt = s.cnt + 1'b1;
            if (s.req.mode == LM_FAST || s.req.mode == LM_HEART)
              last = 1'b1;
            else if (next.cnt == s.req.n)
              next.ph = PH_GAP;
            else
              next.ph = PH_ON;
          end
          default: last = 1'b1;
        endcase
      end
    end
    // a new pattern is taken only where a repetition ends, never mid-code
    if (last)
    begin
      next.done = 1'b1;
      next.req = i_req;
      next.cnt = '0;
      if (i_req.mode == LM_CUR)
        next.ph = PH_LEAD;
      else if (i_req.mode == LM_OFF || (i_req.mode == LM_CODE && i_req.n == 8'h00))
        next.ph = PH_GAP;
      else
        next.ph = PH_ON;
    end
    // led level, registered so the pin is glitch free
    case (next.ph)
      PH_LEAD, PH_ON: next.lvl = LV_ON;
      PH_OFF: next.lvl = (next.req.mode == LM_HEART) ? LV_DIM : LV_OFF;
      default: next.lvl = LV_OFF;
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      s <= LED_RST;
    else
      s <= next;
  end

  assign o_lvl = s.lvl;
  assign o_done = s.done;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_code_gap;
    (s.ph == PH_GAP) |-> (s.lvl == LV_OFF);
  endproperty
  a_code_gap: assert property (p_code_gap) else $error("led not dark in gap");

  property p_heart_dim;
    (s.req.mode == LM_HEART && s.ph == PH_OFF) |-> (s.lvl == LV_DIM);
  endproperty
  a_heart_dim: assert property (p_heart_dim) else $error("heartbeat not dim");

  property p_cur_lead;
    (s.ph == PH_LEAD) |-> (s.lvl == LV_ON && s.req.mode == LM_CUR);
  endproperty
  a_cur_lead: assert property (p_cur_lead) else $error("current lead not steady on");

  property p_hold_req;
    !next.done |=> $stable(s.req);
  endproperty
  a_hold_req: assert property (p_hold_req) else $error("pattern changed mid repetition");

endmodule : ifl_led

/* inc/ifl_pkg.sv */
// ifl_pkg: constants and types of the ignition fault and status LED block
// assumes one 100 MHz clock; all long timers run off a 1 ms tick
package ifl_pkg;

  // ****************************************************************
  // clock and timebase
  // ****************************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam int S_PER_H = 3600;
  localparam int TICK_CYC = CLK_HZ / MS_PER_S; // clock cycles per 1 ms tick
  localparam int PW = 17; // prescaler width, holds TICK_CYC
  localparam int TW = 22; // ms timer width, holds one hour

  // ****************************************************************
  // sequence times in their own units
  // ****************************************************************
  localparam int OOS_S = 10;
  localparam int DAMP_S = 60;
  localparam int RETRY_MIN = 5;
  localparam int HOLD_H = 1;
  localparam int TRIAL_S = 30; // ignition trial length
  localparam int SELF_S = 2; // power-up self check length
  localparam int CODE_HZ = 2;
  localparam int CODE_GAP_S = 2;
  localparam int HEART_MS = 500;
  localparam int CUR_LEAD_S = 4;
  localparam int CUR_FLASH_S = 1;
  localparam int FAST_MS = 100;
  localparam int OFFP_MS = 500; // repetition length of the dark pattern

  // tick counts, minus one, for the sequence timer
  localparam logic [TW-1:0] OOS_T = TW'(OOS_S * MS_PER_S - 1);
  localparam logic [TW-1:0] DAMP_T = TW'(DAMP_S * MS_PER_S - 1);
  localparam logic [TW-1:0] RETRY_T = TW'(RETRY_MIN * S_PER_MIN * MS_PER_S - 1);
  localparam logic [TW-1:0] HOLD_T = TW'(HOLD_H * S_PER_H * MS_PER_S - 1);
  localparam logic [TW-1:0] TRIAL_T = TW'(TRIAL_S * MS_PER_S - 1);
  localparam logic [TW-1:0] SELF_T = TW'(SELF_S * MS_PER_S - 1);

  // tick counts, minus one, for the led phases
  localparam int LW = 12;
  localparam logic [LW-1:0] FAST_L = LW'(FAST_MS - 1);
  localparam logic [LW-1:0] HEART_L = LW'(HEART_MS - 1);
  localparam logic [LW-1:0] CODE_L = LW'(MS_PER_S / (2 * CODE_HZ) - 1);
  localparam logic [LW-1:0] GAP_L = LW'(CODE_GAP_S * MS_PER_S - 1);
  localparam logic [LW-1:0] LEAD_L = LW'(CUR_LEAD_S * MS_PER_S - 1);
  localparam logic [LW-1:0] CFL_L = LW'(CUR_FLASH_S * MS_PER_S / 2 - 1);
  localparam logic [LW-1:0] OFFP_L = LW'(OFFP_MS - 1);

  // ****************************************************************
  // flash codes and flame current scaling
  // ****************************************************************
  localparam logic [7:0] CODE_NOFLAME = 8'h02;
  localparam logic [7:0] CODE_RECYCLE = 8'h03;
  localparam logic [7:0] CODE_OOS = 8'h04;
  localparam logic [7:0] CODE_DAMP = 8'h05;
  localparam logic [7:0] CODE_INTERNAL = 8'h06;
  localparam logic [7:0] CODE_ROD = 8'h07;
  localparam logic [7:0] CODE_LOWV = 8'h08;
  localparam int CUR_FRAC = 2; // flame current input in quarter microamps
  localparam logic [8:0] CUR_HALF = 9'h002; // half a microamp, for rounding

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [10:0] {
    ST_SELF = 11'h001, ST_IDLE = 11'h002, ST_DOPEN = 11'h004, ST_TRIAL = 11'h008,
    ST_RUN = 11'h010, ST_RETRY = 11'h020, ST_OOS = 11'h040, ST_HOLD = 11'h080,
    ST_DERR = 11'h100, ST_DCLOSE = 11'h200, ST_WAIT = 11'h400
  } ifl_st_e;
  typedef enum logic [4:0] {
    LM_OFF = 5'h01, LM_FAST = 5'h02, LM_HEART = 5'h04, LM_CODE = 5'h08, LM_CUR = 5'h10
  } ifl_lm_e;
  typedef enum logic [3:0] {PH_LEAD = 4'h1, PH_ON = 4'h2, PH_OFF = 4'h4, PH_GAP = 4'h8} ifl_ph_e;
  typedef enum logic [1:0] {LV_OFF = 2'h0, LV_DIM = 2'h1, LV_ON = 2'h2} ifl_lv_e;

  typedef struct packed {
    ifl_lm_e mode;
    logic [7:0] n;
  } ifl_req_s;
  typedef struct packed {
    logic heat;
    logic flame;
    logic damp_req;
    logic damp_present;
    logic damp_open;
    logic int_err;
    logic rod_short;
    logic low_volt;
  } ifl_pins_s;
  typedef struct packed {
    logic pilot;
    logic spark;
    logic main;
    logic damp;
  } ifl_act_s;
  typedef struct packed {
    ifl_req_s req;
    ifl_ph_e ph;
    logic [7:0] cnt;
    logic [LW-1:0] tmr;
    ifl_lv_e lvl;
    logic done;
  } ifl_led_s;
  typedef struct packed {
    ifl_st_e st;
    logic [TW-1:0] tmr;
    logic [PW-1:0] pre;
    logic tick;
    logic rec;
    logic long_oos;
    ifl_act_s act;
    ifl_pins_s sync1;
    ifl_pins_s sync2;
    ifl_req_s req;
  } ifl_top_s;

  // reset values
  localparam ifl_req_s REQ_RST = '{mode: LM_OFF, n: 8'h00};
  localparam ifl_led_s LED_RST = '{req: REQ_RST, ph: PH_GAP, cnt: 8'h00, tmr: '0,
                                   lvl: LV_OFF, done: 1'b0};
  localparam ifl_top_s TOP_RST = '{st: ST_SELF, tmr: '0, pre: '0, tick: 1'b0, rec: 1'b0,
                                   long_oos: 1'b0, act: '0, sync1: '0, sync2: '0,
                                   req: '{mode: LM_FAST, n: 8'h00}};

endpackage : ifl_pkg

/* sim/ifl_ctrl_bench.sv */
// ifl_ctrl_bench: self-checking run of the fault supervisor and led patterns
// assumes ifl_eye times the led; timebase cut to 4 clocks per ms
`timescale 1ns/10ps
module ifl_ctrl_bench
  import ifl_pkg::*;
();
  // ****************************************************************
  // stimulus and observers
  // ****************************************************************
  localparam int P = 4;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  ifl_pins_s pins = '0;
  logic [7:0] cur = 8'h0a; // 2.5 uA, a rounding boundary
  logic o_pilot, o_spark, o_main, o_damp;
  ifl_st_e o_state;
  ifl_req_s o_shown;
  ifl_lv_e o_led_lvl, e_prev;
  logic [31:0] e_len;
  logic [7:0] e_burst;
  logic e_end, e_rep;
  int bad_count = 0;
  int checks = 0;
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  ifl_ctrl #(.TICK_CYC_P(P)) uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_pins(pins),
    .i_flame_cur(cur), .o_pilot(o_pilot), .o_spark(o_spark), .o_main(o_main),
    .o_damp(o_damp), .o_state(o_state), .o_shown(o_shown), .o_led_lvl(o_led_lvl));
  ifl_eye eye (.i_clk(i_clk), .i_lvl(o_led_lvl), .o_len(e_len), .o_prev(e_prev),
    .o_end(e_end), .o_burst(e_burst), .o_rep(e_rep));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // bounded waits; running out ends the run at once
  task automatic lost();
    bad_count++;
    $display("timeout at %0t", $time);
    conclude();
  endtask : lost
  task automatic wait_st(input ifl_st_e s, input int n);
    int i;
    for (i = 0; i < n && o_state !== s; i++)
      @(negedge i_clk);
    if (o_state !== s)
      lost();
  endtask : wait_st
  // k-th finished run of level lv, or k-th closed burst when rep is set
  task automatic await(input logic rep, input ifl_lv_e lv, input int k);
    int i;
    int m;
    m = 0;
    for (i = 0; i < 60000 && m < k; i++)
    begin
      @(negedge i_clk);
      if (rep ? e_rep === 1'b1 : (e_end === 1'b1 && e_prev === lv))
        m++;
    end
    if (m < k)
      lost();
  endtask : await
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_start();
    chk(o_state, ST_SELF);
    chk(o_shown, {LM_FAST, 8'h00});
    chk({o_pilot, o_spark, o_main, o_damp}, 4'h0);
    await(1'b0, LV_ON, 2);
    chk(e_len, 32'(FAST_MS * P));
    wait_st(ST_IDLE, 9000);
    chk(o_shown.mode, LM_OFF);
    $display("test start done");
  endtask : t_start
  // each fault parks in wait and leaves it on its own once cleared
  task automatic t_fault();
    int i;
    for (i = 0; i < 3; i++)
    begin
      pins[2-i] = 1'b1;
      wait_st(ST_WAIT, 20);
      chk(o_shown, {LM_CODE, CODE_INTERNAL + 8'(i)});
      chk(o_pilot, 1'b0);
      if (i == 0)
      begin
        await(1'b1, LV_OFF, 2);
        chk(e_burst, CODE_INTERNAL);
        chk(e_len, 32'((MS_PER_S / (2 * CODE_HZ) + CODE_GAP_S * MS_PER_S) * P));
      end
      pins[2-i] = 1'b0;
      wait_st(ST_IDLE, 20);
    end
    $display("test faults done");
  endtask : t_fault
  task automatic t_oos();
    pins.flame = 1'b1;
    wait_st(ST_OOS, 20);
    chk(o_shown, {LM_CODE, CODE_OOS});
    pins.flame = 1'b0;
    wait_st(ST_IDLE, 20);
    $display("test stray flame done");
  endtask : t_oos
  // missing damper, then a full light-off with one flame loss
  task automatic t_run();
    pins.damp_req = 1'b1;
    pins.heat = 1'b1;
    wait_st(ST_DERR, 20);
    chk(o_shown, {LM_CODE, CODE_DAMP});
    pins.damp_present = 1'b1;
    pins.damp_open = 1'b1;
    wait_st(ST_TRIAL, 40);
    chk({o_pilot, o_spark, o_main, o_damp}, 4'hd);
    chk(o_shown.mode, LM_HEART);
    await(1'b0, LV_DIM, 1);
    chk(e_len, 32'(HEART_MS * P));
    pins.flame = 1'b1;
    wait_st(ST_RUN, 20);
    chk({o_pilot, o_spark, o_main}, 3'h5);
    chk(o_shown, {LM_CUR, 8'h03});
    pins.flame = 1'b0;
    wait_st(ST_TRIAL, 20);
    chk(o_shown, {LM_CODE, CODE_RECYCLE});
    chk(o_spark, 1'b1);
    pins.flame = 1'b1;
    wait_st(ST_RUN, 20);
    chk(o_shown.mode, LM_CUR);
    $display("test run done");
  endtask : t_run
  // heat ends with the flame left burning; over 10 s of it forces the long hold
  task automatic t_hold();
    pins.heat = 1'b0;
    wait_st(ST_DCLOSE, 20);
    chk({o_pilot, o_main, o_damp}, 3'h0);
    chk(o_shown.mode, LM_OFF);
    pins.damp_open = 1'b0;
    wait_st(ST_OOS, 20);
    repeat (OOS_S * MS_PER_S * P + 40) @(negedge i_clk);
    chk(o_state, ST_OOS);
    pins.flame = 1'b0;
    wait_st(ST_HOLD, 20);
    chk(o_shown, {LM_CODE, CODE_OOS});
    repeat (40) @(negedge i_clk);
    chk(o_state, ST_HOLD);
    $display("test long stray flame done");
  endtask : t_hold
  initial
  begin
    repeat (6) @(negedge i_clk);
    i_rstn = 1'b1;
    t_start();
    t_fault();
    t_oos();
    t_run();
    t_hold();
    conclude();
  end
endmodule : ifl_ctrl_bench

/* sim/ifl_eye.sv */
// ifl_eye: a service person reading the status led, timing each lit or dark run
// assumes the led level is registered on the same clock as the bench
`timescale 1ns/10ps
module ifl_eye
  import ifl_pkg::*;
(
  input wire logic i_clk,
  input wire ifl_lv_e i_lvl,
  output logic [31:0] o_len,
  output ifl_lv_e o_prev,
  output logic o_end,
  output logic [7:0] o_burst,
  output logic o_rep
);
  // ****************************************************************
  // run timing
  // ****************************************************************
  logic [31:0] run = 32'h0;
  logic [7:0] ons = 8'h00;
  ifl_lv_e last = LV_OFF;
  initial
  begin
    o_len = 32'h0;
    o_prev = LV_OFF;
    o_end = 1'b0;
    o_burst = 8'h00;
    o_rep = 1'b0;
  end
  // a dark run over 1 s closes a burst; flash gaps inside a code are shorter
  always @(posedge i_clk)
  begin
    o_end <= 1'b0;
    o_rep <= 1'b0;
    last <= i_lvl;
    run <= (i_lvl !== last) ? 32'h1 : run + 32'h1;
    if (i_lvl !== last)
    begin
      o_len <= run;
      o_prev <= last;
      o_end <= 1'b1;
      ons <= (last == LV_ON) ? ons + 8'h01 : ons;
      if (last == LV_OFF && run > 32'h00000fa0)
      begin
        o_burst <= ons;
        o_rep <= 1'b1;
        ons <= 8'h00;
      end
    end
  end
endmodule : ifl_eye
